// >>> logic/vas_hold_filter.sv
// minimum-hold qualifier for the synchronised reset command level
// assumes level_in is already on clk_in
module vas_hold_filter
  import vas_pkg::*;
#(
  parameter int HOLD_CYC = RESET_HOLD_CYC
) (
  input  wire logic clk_in,
  input  wire logic srst_in,
  input  wire logic level_in,
  output logic      accept_out
);

  localparam int CNT_W = $clog2(HOLD_CYC + 1);

  // refuse counts the qualifier cannot serve
  if (HOLD_CYC < 2) begin : g_hold_check
    $error("hold count too small");
  end

  logic [CNT_W-1:0] count;
  logic             fired;
  wire              at_end = (count == CNT_W'(HOLD_CYC - 1));

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      count <= '0;
      fired <= 1'b0;
    end else if (!level_in) begin
      count <= '0;
      fired <= 1'b0;
    end else if (!at_end) begin
      count <= count + CNT_W'(1);
    end else begin
      fired <= 1'b1;
    end
  end

  assign accept_out = level_in && at_end && !fired;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  property p_accept_needs_hold;
    accept_out |-> level_in && count == CNT_W'(HOLD_CYC - 1);
  endproperty
  a_accept_needs_hold : assert property (p_accept_needs_hold)
    else $error("reset accepted before full hold");

  property p_accept_once;
    accept_out |=> !accept_out;
  endproperty
  a_accept_once : assert property (p_accept_once)
    else $error("reset accepted twice in one hold");

endmodule // vas_hold_filter

// >>> logic/vas_pkg.sv
// constants, types and helpers for the valve actuator supervisor
// assumes one 20 MHz system clock and same-clock converter words
package vas_pkg;

  localparam int CLK_HZ        = 20_000_000;
  localparam int RESET_HOLD_MS = 500;
  localparam int RESET_HOLD_CYC = (CLK_HZ / 1000) * RESET_HOLD_MS;

  localparam int POS_W   = 12;
  localparam int UA_W    = 16;
  localparam int TEMP_W  = 8;
  localparam int N_WIND  = 3;
  localparam int FAULT_W = 8;
  localparam int LOG_W   = FAULT_W + 2;
  localparam int PIDX_W  = 2;
  localparam int N_PARAM = 3;

  localparam logic [UA_W-1:0]  UA_MIN  = 16'h0FA0;
  localparam logic [UA_W-1:0]  UA_MAX  = 16'h4E20;
  localparam logic [UA_W-1:0]  UA_SPAN = 16'h3E80;
  localparam logic [POS_W-1:0] POS_MAX = 12'hFFF;
  localparam logic [POS_W-1:0] POS_HOME = 12'h000;

  localparam logic [TEMP_W-1:0] WIND_HOT_NEW = 8'h87;
  localparam logic [TEMP_W-1:0] WIND_HOT_OLD = 8'h82;
  localparam logic [TEMP_W-1:0] ELEC_HOT     = 8'h6E;
  localparam logic [1:0]        HOT_MIN_CNT  = 2'h2;

  localparam logic [PIDX_W-1:0] PIX_STOP     = 2'h0;
  localparam logic [PIDX_W-1:0] PIX_HOME_WIN = 2'h1;
  localparam logic [PIDX_W-1:0] PIX_DEADBAND = 2'h2;

  localparam logic [POS_W-1:0] STOP_DEF     = 12'h000;
  localparam logic [POS_W-1:0] HOME_WIN_DEF = 12'h004;
  localparam logic [POS_W-1:0] DEADBAND_DEF = 12'h002;

  localparam int LOG_MOTOR_HOT = FAULT_W;
  localparam int LOG_ELEC_HOT  = FAULT_W + 1;

  typedef enum logic [1:0] {
    GEN_OLD,
    GEN_MID,
    GEN_NEW
  } vas_gen_type;

  // 4..20 mA in microamps onto 0..POS_MAX, clamped
  function automatic logic [POS_W-1:0] ua_to_pos(input logic [UA_W-1:0] ua);
    logic [31:0] prod;
    prod = 32'h0;
    if (ua <= UA_MIN) begin
      return POS_HOME;
    end
    if (ua >= UA_MAX) begin
      return POS_MAX;
    end
    prod = (32'(ua - UA_MIN) * 32'(POS_MAX)) / 32'(UA_SPAN);
    return prod[POS_W-1:0];
  endfunction

  // 0..full onto 4000..20000 microamps
  function automatic logic [UA_W-1:0] frac_to_ua(input logic [POS_W-1:0] val,
                                                 input logic [POS_W-1:0] full);
    logic [31:0] prod;
    prod = (32'(val) * 32'(UA_SPAN)) / 32'(full);
    return UA_MIN + prod[UA_W-1:0];
  endfunction

endpackage : vas_pkg

// >>> logic/vas_supervisor.sv
// supervisor for an electric fuel-valve actuator: commands, homing,
// demand mapping, feedback scaling, alarms and set-up access
// assumes run/reset pins are asynchronous; converter words are on clk_in
//
// Functional notes
// - after power-up or reset, homing waits until run is on, then starts.
// - while run is on the valve target follows the demand continuously.
// - when run goes off or is lost the valve goes to its stop position; while homing the code stops the motor where it is and waits for run.
// - a reset command clears position state, reloads set-up and rehomes.
// - while reset is active the run and demand inputs are held, not used.
// - reset must be held at least 0.5 s and is accepted only then.
// - demand 4 mA maps to closed home and 20 mA to fully open, linearly.
// - position feedback is 4 mA at home up to 20 mA at full span.
// - load feedback is 4 mA at no load up to 20 mA at full load.
// - each alarm switch is closed while healthy and opens on its fault.
// - the general fault set is chosen by factory strap; any member opens it.
// - newest generation: thermal alarm opens if two windings exceed 135 C.
// - earlier generation: two windings over 130 C or electronics over 110 C.
// - middle generation: electronics over 110 C opens the general fault.
// - the serial host can change set-up and read stored fault history.
// - commutation, position loop and monitoring run with no outside help; the code has no commutation and gives only motor drive and direction.
module vas_supervisor
  import vas_pkg::*;
#(
  parameter int HOLD_CYC = RESET_HOLD_CYC
) (
  input  wire logic                      clk_in,
  input  wire logic                      srst_in,
  input  wire logic                      run_pin_in,
  input  wire logic                      reset_pin_in,
  input  wire logic [UA_W-1:0]           demand_ua_in,
  input  wire logic [POS_W-1:0]          position_in,
  input  wire logic [POS_W-1:0]          load_in,
  input  wire logic [N_WIND*TEMP_W-1:0]  winding_temp_in,
  input  wire logic [TEMP_W-1:0]         elec_temp_in,
  input  wire logic [FAULT_W-1:0]        fault_cond_in,
  input  wire logic [FAULT_W-1:0]        fault_select_in,
  input  wire logic [1:0]                generation_in,
  input  wire logic                      cfg_wr_in,
  input  wire logic                      cfg_rd_in,
  input  wire logic [PIDX_W-1:0]         cfg_addr_in,
  input  wire logic [POS_W-1:0]          cfg_wdata_in,
  input  wire logic                      diag_rd_in,
  input  wire logic                      diag_clear_in,
  output logic [POS_W-1:0]               cfg_rdata_out,
  output logic [LOG_W-1:0]               diag_data_out,
  output logic [POS_W-1:0]               pos_target_out,
  output logic                           motor_drive_out,
  output logic                           motor_open_dir_out,
  output logic                           homed_out,
  output logic [UA_W-1:0]                pos_fb_ua_out,
  output logic [UA_W-1:0]                load_fb_ua_out,
  output logic                           fault_switch_out,
  output logic                           thermal_alarm_switch_out
);

  typedef enum logic [2:0] {
    ST_WAIT_RUN,
    ST_HOMING,
    ST_TRACK,
    ST_STOP,
    ST_RESET
  } vas_state_type;

  function automatic logic [1:0] count_over(input logic [N_WIND*TEMP_W-1:0] t,
                                            input logic [TEMP_W-1:0] thr);
    logic [1:0] n;
    n = 2'h0;
    for (int i = 0; i < N_WIND; i++) begin
      if (t[i*TEMP_W +: TEMP_W] > thr) begin
        n = n + 2'h1;
      end
    end
    return n;
  endfunction

  // pin synchronisers
  logic run_meta, run_sync, rst_meta, rst_active;
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      run_meta   <= 1'b0;
      run_sync   <= 1'b0;
      rst_meta   <= 1'b0;
      rst_active <= 1'b0;
    end else begin
      run_meta   <= run_pin_in;
      run_sync   <= run_meta;
      rst_meta   <= reset_pin_in;
      rst_active <= rst_meta;
    end
  end

  logic reset_accept;
  vas_hold_filter #(
    .HOLD_CYC (HOLD_CYC)
  ) u_hold (
    .clk_in     (clk_in),
    .srst_in    (srst_in),
    .level_in   (rst_active),
    .accept_out (reset_accept)
  );

  logic            run_hold;
  logic [UA_W-1:0] demand_hold;
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      run_hold    <= 1'b0;
      demand_hold <= UA_MIN;
    end else if (!rst_active) begin
      run_hold    <= run_sync;
      demand_hold <= demand_ua_in;
    end
  end
  wire run_eff = rst_active ? run_hold : run_sync;
  wire [UA_W-1:0] demand_eff = rst_active ? demand_hold : demand_ua_in;
  wire [POS_W-1:0] demand_pos = ua_to_pos(demand_eff);
  // factory straps, caught after reset release
  logic              strap_taken;
  vas_gen_type       gen;
  logic [FAULT_W-1:0] fault_select;
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      strap_taken  <= 1'b0;
      gen          <= GEN_NEW;
      fault_select <= '0;
    end else if (!strap_taken) begin
      strap_taken  <= 1'b1;
      gen          <= vas_gen_type'(generation_in);
      fault_select <= fault_select_in;
    end
  end
  // set-up parameters: stored image and working copy
  logic [POS_W-1:0] param_store [N_PARAM];
  logic [POS_W-1:0] param_act   [N_PARAM];
  wire cfg_hit = cfg_addr_in < PIDX_W'(N_PARAM);
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      param_store[PIX_STOP]     <= STOP_DEF;
      param_store[PIX_HOME_WIN] <= HOME_WIN_DEF;
      param_store[PIX_DEADBAND] <= DEADBAND_DEF;
      param_act[PIX_STOP]       <= STOP_DEF;
      param_act[PIX_HOME_WIN]   <= HOME_WIN_DEF;
      param_act[PIX_DEADBAND]   <= DEADBAND_DEF;
    end else if (reset_accept) begin
      for (int i = 0; i < N_PARAM; i++) begin
        param_act[i] <= param_store[i];
      end
    end else if (cfg_wr_in && cfg_hit) begin
      param_store[cfg_addr_in] <= cfg_wdata_in;
      param_act[cfg_addr_in]   <= cfg_wdata_in;
    end
  end
  wire [POS_W-1:0] stop_pos  = param_act[PIX_STOP];
  wire [POS_W-1:0] home_win  = param_act[PIX_HOME_WIN];
  wire [POS_W-1:0] dead_band = param_act[PIX_DEADBAND];
  // command sequencer
  vas_state_type state, next_state;
  logic          homed, next_homed;
  wire           at_home = position_in <= home_win;
  always_comb begin
    next_state = state;
    next_homed = homed;
    case (state)
      ST_WAIT_RUN: begin
        if (run_eff) begin
          next_state = ST_HOMING;
        end
      end
      ST_HOMING: begin
        if (!run_eff) begin
          next_state = ST_WAIT_RUN;
        end else if (at_home) begin
          next_homed = 1'b1;
          next_state = ST_TRACK;
        end
      end
      ST_TRACK: begin
        if (!run_eff) begin
          next_state = ST_STOP;
        end
      end
      ST_STOP: begin
        if (run_eff) begin
          next_state = ST_TRACK;
        end
      end
      ST_RESET: begin
        if (!rst_active) begin
          next_state = ST_WAIT_RUN;
        end
      end
      default: begin
        next_state = ST_WAIT_RUN;
      end
    endcase
    if (reset_accept) begin
      next_state = ST_RESET;
      next_homed = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state <= ST_WAIT_RUN;
      homed <= 1'b0;
    end else begin
      state <= next_state;
      homed <= next_homed;
    end
  end

  wire [POS_W-1:0] next_target =
    (state == ST_HOMING) ? POS_HOME :
    (state == ST_TRACK)  ? demand_pos :
    (state == ST_STOP)   ? stop_pos : position_in;
  wire moving = (state == ST_HOMING) || (state == ST_TRACK) || (state == ST_STOP);
  wire             want_open = next_target > position_in;
  wire [POS_W-1:0] pos_err   = want_open ? next_target - position_in
                                         : position_in - next_target;
  wire             next_drive = moving && (pos_err > dead_band);
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pos_target_out     <= POS_HOME;
      motor_drive_out    <= 1'b0;
      motor_open_dir_out <= 1'b0;
      homed_out          <= 1'b0;
      pos_fb_ua_out      <= UA_MIN;
      load_fb_ua_out     <= UA_MIN;
    end else begin
      pos_target_out     <= next_target;
      motor_drive_out    <= next_drive;
      motor_open_dir_out <= want_open;
      homed_out          <= homed;
      pos_fb_ua_out      <= frac_to_ua(position_in, POS_MAX);
      load_fb_ua_out     <= frac_to_ua(load_in, POS_MAX);
    end
  end
  // temperature detection per generation
  wire [1:0] hot_new   = count_over(winding_temp_in, WIND_HOT_NEW);
  wire [1:0] hot_old   = count_over(winding_temp_in, WIND_HOT_OLD);
  wire       elec_hot  = elec_temp_in > ELEC_HOT;
  wire       motor_hot = (gen == GEN_NEW) ? (hot_new >= HOT_MIN_CNT)
                                          : (hot_old >= HOT_MIN_CNT);
  wire thermal_trip = motor_hot || ((gen == GEN_OLD) && elec_hot);
  wire fault_trip = |(fault_cond_in & fault_select) || ((gen == GEN_MID) && elec_hot);
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      fault_switch_out         <= 1'b0;
      thermal_alarm_switch_out <= 1'b0;
    end else begin
      fault_switch_out         <= strap_taken && !fault_trip;
      thermal_alarm_switch_out <= strap_taken && !thermal_trip;
    end
  end

  logic [LOG_W-1:0] fault_log;
  wire  [LOG_W-1:0] log_set = {elec_hot, motor_hot, fault_cond_in};
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      fault_log <= '0;
    end else if (diag_clear_in) begin
      fault_log <= log_set;
    end else begin
      fault_log <= fault_log | log_set;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cfg_rdata_out <= '0;
      diag_data_out <= '0;
    end else begin
      if (cfg_rd_in) begin
        cfg_rdata_out <= cfg_hit ? param_store[cfg_addr_in] : '0;
      end
      if (diag_rd_in) begin
        diag_data_out <= fault_log;
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  property p_home_needs_run;
    (state == ST_WAIT_RUN && !run_eff && !reset_accept) |=> state != ST_HOMING;
  endproperty
  a_home_needs_run : assert property (p_home_needs_run)
    else $error("homing began without run");
  property p_track_follows;
    (state == ST_TRACK) |=> pos_target_out == $past(demand_pos);
  endproperty
  a_track_follows : assert property (p_track_follows)
    else $error("target did not follow demand");
  property p_run_loss_stops;
    (state == ST_TRACK && !run_eff && !reset_accept) |=> state == ST_STOP
      ##1 pos_target_out == $past(stop_pos);
  endproperty
  a_run_loss_stops : assert property (p_run_loss_stops)
    else $error("run loss did not go to stop");
  property p_reset_reload;
    reset_accept |=> !homed && state == ST_RESET && stop_pos == param_store[PIX_STOP];
  endproperty
  a_reset_reload : assert property (p_reset_reload)
    else $error("reset did not clear and reload");
  property p_reset_ignores_inputs;
    rst_active && $past(rst_active) |-> run_eff == $past(run_eff)
      && demand_eff == $past(demand_eff);
  endproperty
  a_reset_ignores_inputs : assert property (p_reset_ignores_inputs)
    else $error("input used during reset");
  property p_demand_ends;
    (demand_eff <= UA_MIN |-> demand_pos == POS_HOME)
      and (demand_eff >= UA_MAX |-> demand_pos == POS_MAX);
  endproperty
  a_demand_ends : assert property (p_demand_ends)
    else $error("demand end points wrong");
  property p_pos_fb_ends;
    (position_in == POS_HOME |=> pos_fb_ua_out == UA_MIN)
      and (position_in == POS_MAX |=> pos_fb_ua_out == UA_MAX);
  endproperty
  a_pos_fb_ends : assert property (p_pos_fb_ends)
    else $error("position feedback end points wrong");
  property p_load_fb_ends;
    (load_in == POS_HOME |=> load_fb_ua_out == UA_MIN)
      and (load_in == POS_MAX |=> load_fb_ua_out == UA_MAX);
  endproperty
  a_load_fb_ends : assert property (p_load_fb_ends)
    else $error("load feedback end points wrong");
  property p_thermal_new;
    (gen == GEN_NEW && hot_new >= 2'h2) |=> !thermal_alarm_switch_out;
  endproperty
  a_thermal_new : assert property (p_thermal_new)
    else $error("thermal alarm stayed closed");
  property p_elec_mid;
    (gen == GEN_MID && elec_hot) |=> !fault_switch_out;
  endproperty
  a_elec_mid : assert property (p_elec_mid)
    else $error("electronics heat did not open fault");
  property p_alarm_start_open;
    $fell(srst_in) |-> !fault_switch_out && !thermal_alarm_switch_out;
  endproperty
  a_alarm_start_open : assert property (@(posedge clk_in) p_alarm_start_open)
    else $error("alarm closed during reset");
  c_homing_done : cover property (state == ST_HOMING ##1 state == ST_TRACK);
  c_stop_entry  : cover property (state == ST_TRACK ##1 state == ST_STOP);
  c_reset_taken : cover property (reset_accept);
  c_thermal_open : cover property ($fell(thermal_alarm_switch_out));

endmodule // vas_supervisor

// >>> tb/test_vas_supervisor.sv
// self-checking bench for the valve actuator supervisor
// assumes the plant model closes the position loop; reset hold shortened
module test_vas_supervisor
  import vas_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int HOLD = 16;

  typedef struct {
    int          kind;
    logic [15:0] exp;
  } vas_note_type;

  logic              clk_in = 1'b0;
  logic              srst_in = 1'b1;
  logic              run = 1'b0;
  logic              rst_pin = 1'b0;
  logic [UA_W-1:0]   demand = 16'h0FA0;
  logic [POS_W-1:0]  position;
  logic [POS_W-1:0]  load = 12'h000;
  logic [23:0]       wtemp = 24'h000000;
  logic [7:0]        etemp = 8'h00;
  logic [7:0]        fcond = 8'h00;
  logic [7:0]        fsel = 8'h00;
  logic [1:0]        gen = 2'h2;
  logic              cfg_wr = 1'b0;
  logic              cfg_rd = 1'b0;
  logic [1:0]        cfg_addr = 2'h0;
  logic [11:0]       cfg_wdata = 12'h000;
  logic              diag_rd = 1'b0;
  logic              diag_clr = 1'b0;
  logic [11:0]       cfg_rdata;
  logic [9:0]        diag_data;
  logic [11:0]       target;
  logic              drive;
  logic              open_dir;
  logic              homed;
  logic [15:0]       pos_fb;
  logic [15:0]       load_fb;
  logic              fsw;
  logic              tsw;
  int                fail_count = 0;
  int                total_checks = 0;
  logic [31:0]       seed = 32'h2BC9;
  vas_note_type      notes[$];
  vas_note_type      n;

  always #25 clk_in = ~clk_in;

  vas_supervisor #(.HOLD_CYC(HOLD)) DUT (
    .clk_in(clk_in), .srst_in(srst_in), .run_pin_in(run), .reset_pin_in(rst_pin),
    .demand_ua_in(demand), .position_in(position), .load_in(load),
    .winding_temp_in(wtemp), .elec_temp_in(etemp), .fault_cond_in(fcond),
    .fault_select_in(fsel), .generation_in(gen), .cfg_wr_in(cfg_wr),
    .cfg_rd_in(cfg_rd), .cfg_addr_in(cfg_addr), .cfg_wdata_in(cfg_wdata),
    .diag_rd_in(diag_rd), .diag_clear_in(diag_clr), .cfg_rdata_out(cfg_rdata),
    .diag_data_out(diag_data), .pos_target_out(target), .motor_drive_out(drive),
    .motor_open_dir_out(open_dir), .homed_out(homed), .pos_fb_ua_out(pos_fb),
    .load_fb_ua_out(load_fb), .fault_switch_out(fsw), .thermal_alarm_switch_out(tsw)
  );

  vas_valve_plant plant (
    .clk_in(clk_in), .drive_in(drive), .open_dir_in(open_dir), .position_out(position)
  );

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [15:0] exp_pos(input int ua);
    if (ua <= 4000) return 16'h0000;
    if (ua >= 20000) return 16'h0FFF;
    return 16'((ua - 4000) * 4095 / 16000);
  endfunction

  function automatic logic [15:0] exp_fb(input int v);
    return 16'(4000 + v * 16000 / 4095);
  endfunction

  task automatic tick(input int cnt);
    repeat (cnt) @(posedge clk_in);
    #2;
  endtask

  task automatic note(input int kind, input logic [15:0] exp);
    notes.push_back('{kind, exp});
  endtask

  task automatic check_word(input logic [15:0] exp, input logic [15:0] act);
    total_checks++;
    if (act !== exp) begin
      fail_count++;
      $display("ERROR %0t word expected %h got %h", $time, exp, act);
    end
  endtask

  task automatic check_bit(input int kind, input logic exp, input logic act);
    total_checks++;
    if (act !== exp) begin
      fail_count++;
      $display("ERROR %0t flag %0d expected %b got %b", $time, kind, exp, act);
    end
  endtask

  // oldest note against the output it names
  always begin
    wait (notes.size() != 0);
    n = notes.pop_front();
    case (n.kind)
      0: check_word(n.exp, 16'(target));
      1: check_word(n.exp, pos_fb);
      2: check_word(n.exp, load_fb);
      3: check_bit(3, n.exp[0], homed);
      4: check_bit(4, n.exp[0], fsw);
      5: check_bit(5, n.exp[0], tsw);
      6: check_word(n.exp, 16'(cfg_rdata));
      8: check_bit(8, n.exp[0], drive);
      9: check_bit(9, n.exp[0], open_dir);
      default: check_word(n.exp, 16'(diag_data));
    endcase
  end

  task automatic cfg_write(input logic [1:0] a, input logic [11:0] d);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    tick(1);
    cfg_wr = 1'b0;
  endtask

  task automatic cfg_read(input logic [1:0] a, input logic [11:0] exp);
    cfg_rd = 1'b1;
    cfg_addr = a;
    tick(1);
    cfg_rd = 1'b0;
    tick(1);
    note(6, 16'(exp));
  endtask

  task automatic wait_homed();
    for (int i = 0; i < 600 && homed !== 1'b1; i++) tick(1);
    note(3, 16'h0001);
  endtask

  task automatic finish_test();
    if (fail_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_in);
    fail_count++;
    $display("ERROR %0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    int          d;
    int          hot;
    int          thr;
    logic        ehot;
    logic [11:0] p;
    logic [11:0] l;
    fsel = 8'(rnd());
    tick(8);
    srst_in = 1'b0;
    tick(1);
    note(4, 16'h0000);
    note(5, 16'h0000);
    note(1, exp_fb(position));
    tick(10);
    note(3, 16'h0000);
    note(8, 16'h0000);
    run = 1'b1;
    wait_homed();
    for (int i = 0; i < 10; i++) begin
      d = (i == 0) ? 4000 : (i == 1) ? 20000 : 4000 + int'(rnd() % 16001);
      demand = 16'(d);
      tick(3);
      note(0, exp_pos(d));
      if (i == 1) begin
        note(8, 16'h0001);
        note(9, 16'h0001);
      end
      p = position;
      l = (i == 0) ? 12'h000 : (i == 1) ? 12'hFFF : 12'(rnd());
      load = l;
      tick(1);
      note(1, exp_fb(p));
      note(2, exp_fb(l));
    end
    cfg_write(2'h3, 12'hABC);
    cfg_read(2'h3, 12'h000);
    cfg_write(2'h0, 12'h123);
    cfg_read(2'h0, 12'h123);
    cfg_read(2'h1, 12'h004);
    cfg_read(2'h2, 12'h002);
    demand = 16'd12000;
    tick(3);
    rst_pin = 1'b1;
    tick(3);
    run = 1'b0;
    demand = 16'd20000;
    tick(5);
    note(0, exp_pos(12000));
    rst_pin = 1'b0;
    run = 1'b1;
    demand = 16'd12000;
    tick(4);
    note(3, 16'h0001);
    run = 1'b0;
    tick(6);
    note(0, 16'h0123);
    rst_pin = 1'b1;
    run = 1'b1;
    tick(HOLD + 6);
    note(3, 16'h0000);
    cfg_read(2'h0, 12'h123);
    rst_pin = 1'b0;
    wait_homed();
    diag_clr = 1'b1;
    tick(1);
    diag_clr = 1'b0;
    fcond = 8'h05;
    tick(1);
    fcond = 8'h00;
    diag_rd = 1'b1;
    tick(1);
    diag_rd = 1'b0;
    tick(1);
    note(7, 16'h0005);
    for (int g = 0; g < 3; g++) begin
      srst_in = 1'b1;
      gen = 2'(g);
      fsel = 8'(rnd());
      tick(2);
      srst_in = 1'b0;
      tick(2);
      thr = (g == 2) ? 135 : 130;
      for (int t = 0; t < 12; t++) begin
        hot = 0;
        for (int k = 0; k < 3; k++) begin
          wtemp[k*8+:8] = 8'(125 + rnd() % 15);
          if (int'(wtemp[k*8+:8]) > thr) hot++;
        end
        etemp = 8'(105 + rnd() % 10);
        ehot = etemp > 8'h6E;
        fcond = 8'(rnd() & rnd() & rnd());
        tick(2);
        note(4, 16'(!(|(fcond & fsel) || (g == 1 && ehot))));
        note(5, 16'(!(hot >= 2 || (g == 0 && ehot))));
      end
    end
    tick(2);
    finish_test();
  end
endmodule // test_vas_supervisor

// >>> tb/vas_valve_plant.sv
// valve plant model: measured position follows the motor drive
// assumes drive and direction are registered on clk_in, one step a cycle
module vas_valve_plant
  import vas_pkg::*;
#(
  parameter logic [POS_W-1:0] START = 12'h040
) (
  input  wire logic             clk_in,
  input  wire logic             drive_in,
  input  wire logic             open_dir_in,
  output logic      [POS_W-1:0] position_out
);
  timeunit 1ns;
  timeprecision 1ns;

  initial position_out = START;

  always @(posedge clk_in) begin
    if (drive_in && open_dir_in && position_out != POS_MAX) begin
      position_out <= position_out + 12'h001;
    end else if (drive_in && !open_dir_in && position_out != POS_HOME) begin
      position_out <= position_out - 12'h001;
    end
  end
endmodule // vas_valve_plant
